// ### include/hpp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hpp_if;
  import hpp_pkg::*;
  // shared data/address pins, resolved from the two enables
  logic [7:0] bus_dev_o;
  logic bus_dev_oe;
  logic [7:0] bus_host_o;
  logic bus_host_oe;
  logic [7:0] host_bus_byte;
  logic data_strobe_n;
  logic rd_n;
  logic wr_n;
  logic ale;
  logic irq_dev_oe;
  logic irq_n;

  assign host_bus_byte = bus_dev_oe ? bus_dev_o : (bus_host_oe ? bus_host_o : 8'h00);
  // open drain line with pull-up
  assign irq_n = irq_dev_oe ? 1'b0 : 1'b1;

  modport dev (
    input host_bus_byte, data_strobe_n, rd_n, wr_n, ale,
    output bus_dev_o, bus_dev_oe, irq_dev_oe
  );
  modport host (
    input host_bus_byte, irq_n,
    output bus_host_o, bus_host_oe, data_strobe_n, rd_n, wr_n, ale
  );
endinterface
`default_nettype wire

// ### include/hpp_pkg.sv
`default_nettype none
package hpp_pkg;
  // host port operating modes, fixed by straps on the device side
  typedef enum logic [1:0] {
    HPP_MODE_HW = 2'h0,
    HPP_MODE_STROBE = 2'h1,
    HPP_MODE_RDWR = 2'h3,
    HPP_MODE_SERIAL = 2'h2
  } hpp_mode_t;

  localparam int HPP_DATA_W = 8;
  localparam int HPP_NUM_COND = 2;
  localparam int HPP_COND_AIS = 0;
  localparam int HPP_COND_LOS = 1;
  localparam logic [7:0] HPP_BYTE_RST = 8'h00;
  localparam logic [7:0] HPP_ADDR_RST = 8'h00;
  // host side timing base in cycles; strobe lasts this plus four, gap this plus one
  localparam int HPP_STROBE_CYC = 3;
  localparam int HPP_CNT_W = 3;
endpackage
`default_nettype wire

// ### rtl/hpp_device.sv
`timescale 1ns/100ps
`default_nettype none
module hpp_device (
  input wire logic sys_clk,
  input wire logic sys_rst,
  hpp_if.dev port,
  input wire hpp_pkg::hpp_mode_t mode,
  input wire logic muxed,
  input wire logic [hpp_pkg::HPP_NUM_COND-1:0] status_in,
  input wire logic [hpp_pkg::HPP_NUM_COND-1:0] irq_enable,
  input wire logic [hpp_pkg::HPP_NUM_COND-1:0] irq_clear,
  input wire logic [7:0] rd_data,
  output logic [7:0] reg_addr,
  output logic [7:0] wr_data,
  output logic wr_pulse,
  output logic rd_pulse,
  output logic [hpp_pkg::HPP_NUM_COND-1:0] pending
);
  import hpp_pkg::*;

  // pin synchronisers: stage one feeds stage two only
  logic ds_s1_q, ds_s2_q, rd_s1_q, rd_s2_q, wr_s1_q, wr_s2_q, ale_s1_q, ale_s2_q;
  logic [7:0] bus_s1_q, bus_s2_q;
  logic [HPP_NUM_COND-1:0] st_s1_q, st_s2_q, st_prev_q;
  logic ds_s1_d, ds_s2_d;
  logic rd_s1_d, rd_s2_d;
  logic wr_s1_d, wr_s2_d;
  logic ale_s1_d, ale_s2_d;
  logic [7:0] bus_s1_d, bus_s2_d;
  logic [HPP_NUM_COND-1:0] st_s1_d, st_s2_d, st_prev_d;

  // next values; metastability is kept inside stage one, logic reads stage two
  always_comb begin
    ds_s1_d = port.data_strobe_n;
    ds_s2_d = ds_s1_q;
    rd_s1_d = port.rd_n;
    rd_s2_d = rd_s1_q;
    wr_s1_d = port.wr_n;
    wr_s2_d = wr_s1_q;
    ale_s1_d = port.ale;
    ale_s2_d = ale_s1_q;
    bus_s1_d = port.host_bus_byte;
    bus_s2_d = bus_s1_q;
    st_s1_d = status_in;
    st_s2_d = st_s1_q;
    // previous synchronised status, for change detection
    st_prev_d = st_s2_q;
  end

  // strobes reset to their idle high level so no false opening edge follows reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ds_s1_q <= 1'b1;
      ds_s2_q <= 1'b1;
      rd_s1_q <= 1'b1;
      rd_s2_q <= 1'b1;
      wr_s1_q <= 1'b1;
      wr_s2_q <= 1'b1;
      ale_s1_q <= 1'b0;
      ale_s2_q <= 1'b0;
      bus_s1_q <= HPP_BYTE_RST;
      bus_s2_q <= HPP_BYTE_RST;
      st_s1_q <= '0;
      st_s2_q <= '0;
      st_prev_q <= '0;
    end else begin
      ds_s1_q <= ds_s1_d;
      ds_s2_q <= ds_s2_d;
      rd_s1_q <= rd_s1_d;
      rd_s2_q <= rd_s2_d;
      wr_s1_q <= wr_s1_d;
      wr_s2_q <= wr_s2_d;
      ale_s1_q <= ale_s1_d;
      ale_s2_q <= ale_s2_d;
      bus_s1_q <= bus_s1_d;
      bus_s2_q <= bus_s2_d;
      st_s1_q <= st_s1_d;
      st_s2_q <= st_s2_d;
      st_prev_q <= st_prev_d;
    end
  end

  // bus state
  logic act_q, act_d, ale_prev_q, ale_prev_d;
  logic [7:0] addr_q, addr_d, wdat_q, wdat_d, dout_q, dout_d;
  logic oe_q, oe_d, wp_q, wp_d, rp_q, rp_d;
  logic rd_act, wr_act, sel;

  // which pin qualifies a cycle depends on bus style; hw/serial never respond
  always_comb begin
    sel = 1'b0;
    rd_act = 1'b0;
    wr_act = 1'b0;
    case (mode)
      HPP_MODE_STROBE: begin
        sel = !ds_s2_q;
        rd_act = sel && !rd_s2_q; // read/write level while strobed
        wr_act = sel && rd_s2_q;
      end
      HPP_MODE_RDWR: begin
        rd_act = !rd_s2_q;
        wr_act = !wr_s2_q;
        sel = rd_act || wr_act;
      end
      default: begin
        sel = 1'b0;
      end
    endcase
  end

  // one transfer per strobe; address latched on falling ale when muxed
  always_comb begin
    act_d = sel;
    ale_prev_d = ale_s2_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    dout_d = dout_q;
    oe_d = rd_act;
    wp_d = 1'b0;
    rp_d = 1'b0;
    if (muxed && ale_prev_q && !ale_s2_q) begin
      addr_d = bus_s2_q;
    end
    // act_q blocks a second pulse while the same strobe is still held
    if (sel && !act_q) begin
      wp_d = wr_act;
      rp_d = rd_act;
      if (wr_act) begin
        wdat_d = bus_s2_q;
      end
    end
    // read data follows the source while strobed, so late updates still show
    if (rd_act) begin
      dout_d = rd_data;
    end
  end

  // bus registers; the pins turn round only from a flop
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      act_q <= 1'b0;
      ale_prev_q <= 1'b0;
      addr_q <= HPP_ADDR_RST;
      wdat_q <= HPP_BYTE_RST;
      dout_q <= HPP_BYTE_RST;
      oe_q <= 1'b0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
    end else begin
      act_q <= act_d;
      ale_prev_q <= ale_prev_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // per condition change detect; either edge of a status line counts
  wire [HPP_NUM_COND-1:0] st_chg;
  for (genvar gi = 0; gi < HPP_NUM_COND; gi++) begin : g_chg
    assign st_chg[gi] = st_s2_q[gi] ^ st_prev_q[gi];
  end

  // sticky status-change flags; a new change beats a same-cycle clear
  logic [HPP_NUM_COND-1:0] pend_q, pend_d;
  logic irq_q, irq_d;
  always_comb begin
    pend_d = (pend_q & ~irq_clear) | st_chg;
    // masking only gates the line, a masked change can still be polled
    irq_d = |(pend_q & irq_enable);
  end

  // the line comes from a flop so it never glitches low between edges
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_q <= '0;
      irq_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      irq_q <= irq_d;
    end
  end

  // every pin and output leaves a flop
  assign port.bus_dev_o = dout_q;
  assign port.bus_dev_oe = oe_q;
  assign port.irq_dev_oe = irq_q; // only ever pulls low
  assign reg_addr = addr_q;
  assign wr_data = wdat_q;
  assign wr_pulse = wp_q;
  assign rd_pulse = rp_q;
  assign pending = pend_q;
endmodule
`default_nettype wire

// ### rtl/hpp_host.sv
`timescale 1ns/100ps
`default_nettype none
// host end: issues one access per request in strobe and read/write modes, drives ground when idle
module hpp_host (
  input wire logic sys_clk,
  input wire logic sys_rst,
  hpp_if.host port,
  input wire hpp_pkg::hpp_mode_t mode,
  input wire logic muxed,
  input wire logic req,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic irq_level
);
  import hpp_pkg::*;

  typedef enum logic [1:0] {
    HPP_S_IDLE = 2'h0,
    HPP_S_ADDR = 2'h1,
    HPP_S_STRB = 2'h3,
    HPP_S_GAP = 2'h2
  } hpp_state_t;

  hpp_state_t st_q, st_d;
  logic [HPP_CNT_W-1:0] cnt_q, cnt_d;
  logic wr_q, wr_d, done_q, done_d, irq_s1_q, irq_q;
  logic [7:0] a_q, a_d, w_q, w_d, r_q, r_d;
  logic [7:0] bo_q, bo_d;
  logic boe_q, boe_d, ds_q, ds_d, rd_q, rd_d, wrn_q, wrn_d, ale_q, ale_d;
  logic hw;
  logic busy_q, busy_d;

  assign hw = (mode == HPP_MODE_HW);

  // access sequencer: optional address phase, strobe phase, recovery gap
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    a_d = a_q;
    w_d = w_q;
    r_d = r_q;
    done_d = 1'b0;
    bo_d = 8'h00; // grounded when idle
    boe_d = 1'b1;
    ds_d = !hw;
    rd_d = !hw;
    wrn_d = 1'b1;
    ale_d = 1'b0;
    case (st_q)
      HPP_S_IDLE: begin
        if (req && (mode == HPP_MODE_STROBE || mode == HPP_MODE_RDWR)) begin
          wr_d = req_write;
          a_d = req_addr;
          w_d = req_wdata;
          cnt_d = '0;
          st_d = muxed ? HPP_S_ADDR : HPP_S_STRB;
        end
      end
      HPP_S_ADDR: begin
        bo_d = a_q;
        ale_d = (cnt_q != HPP_CNT_W'(HPP_STROBE_CYC - 1));
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == HPP_CNT_W'(HPP_STROBE_CYC - 1)) begin
          cnt_d = '0;
          st_d = HPP_S_STRB;
        end
      end
      HPP_S_STRB: begin
        bo_d = w_q;
        boe_d = wr_q;
        if (mode == HPP_MODE_STROBE) begin
          ds_d = 1'b0;
          rd_d = wr_q; // read/write select level
        end else begin
          rd_d = wr_q;
          wrn_d = !wr_q;
        end
        cnt_d = cnt_q + 1'b1;
        // byte is sampled after device synchroniser and register latency
        if (cnt_q == HPP_CNT_W'(HPP_STROBE_CYC + 3)) begin
          if (!wr_q) begin
            r_d = port.host_bus_byte;
          end
          cnt_d = '0;
          st_d = HPP_S_GAP;
        end
      end
      HPP_S_GAP: begin
        boe_d = wr_q; // after a read, stay off the pins while the device turns round
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == HPP_CNT_W'(HPP_STROBE_CYC)) begin
          done_d = 1'b1;
          st_d = HPP_S_IDLE;
        end
      end
      default: begin
        st_d = HPP_S_IDLE;
      end
    endcase
    busy_d = (st_d != HPP_S_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= HPP_S_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      a_q <= HPP_ADDR_RST;
      w_q <= HPP_BYTE_RST;
      r_q <= HPP_BYTE_RST;
      done_q <= 1'b0;
      bo_q <= HPP_BYTE_RST;
      boe_q <= 1'b0;
      ds_q <= 1'b1;
      rd_q <= 1'b1;
      wrn_q <= 1'b1;
      ale_q <= 1'b0;
      irq_s1_q <= 1'b0;
      irq_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      a_q <= a_d;
      w_q <= w_d;
      r_q <= r_d;
      done_q <= done_d;
      bo_q <= bo_d;
      boe_q <= boe_d;
      ds_q <= ds_d;
      rd_q <= rd_d;
      wrn_q <= wrn_d;
      ale_q <= ale_d;
      irq_s1_q <= !port.irq_n;
      irq_q <= irq_s1_q; // level, never edge
      busy_q <= busy_d;
    end
  end

  assign port.bus_host_o = bo_q;
  assign port.bus_host_oe = boe_q;
  assign port.data_strobe_n = ds_q;
  assign port.rd_n = rd_q;
  assign port.wr_n = wrn_q;
  assign port.ale = ale_q;
  assign busy = busy_q;
  assign done = done_q;
  assign rdata = r_q;
  assign irq_level = irq_q;
endmodule
`default_nettype wire

// ### verif/host_processor_port_pins_tb.sv
`timescale 1ns/100ps
`default_nettype none
module host_processor_port_pins_tb;
  import hpp_pkg::*;
  logic sys_clk, sys_rst, muxed, req, req_write, busy, done, irq_level, wr_pulse, rd_pulse;
  hpp_mode_t mode;
  logic [1:0] status_in, irq_enable, irq_clear, pending;
  logic [7:0] rd_data, req_addr, req_wdata, reg_addr, wr_data, rdata;
  int num_errors, samples_checked;

  hpp_if port ();
  hpp_device u_hpp_device (.sys_clk, .sys_rst, .port(port), .mode, .muxed, .status_in,
    .irq_enable, .irq_clear, .rd_data, .reg_addr, .wr_data, .wr_pulse, .rd_pulse, .pending);
  hpp_host u_hpp_host (.sys_clk, .sys_rst, .port(port), .mode, .muxed, .req, .req_write,
    .req_addr, .req_wdata, .busy, .done, .rdata, .irq_level);
  hpp_props u_hpp_props (.sys_clk, .sys_rst, .host_bus_byte(port.host_bus_byte),
    .bus_dev_oe(port.bus_dev_oe), .bus_host_oe(port.bus_host_oe),
    .data_strobe_n(port.data_strobe_n), .rd_n(port.rd_n), .wr_n(port.wr_n), .ale(port.ale),
    .irq_dev_oe(port.irq_dev_oe), .irq_n(port.irq_n));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one host access; pulse and data are caught as they pass, bounded by 40 cycles
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic seen;
    logic [7:0] wd, ra;
    seen = 0;
    @(posedge sys_clk);
    rd_data <= d;
    req <= 1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge sys_clk);
    req <= 0;
    #1;
    chk(busy, 1);
    repeat (40) begin
      @(posedge sys_clk);
      #1;
      if (w ? wr_pulse : rd_pulse) begin
        seen = 1;
        wd = wr_data;
        ra = reg_addr;
      end
      if (done) break;
    end
    chk(done, 1);
    chk(busy, 0);
    chk(seen, 1);
    chk(w ? wd : rdata, d);
    if (muxed) chk(ra, a);
    @(posedge sys_clk);
    #1;
    chk(port.host_bus_byte, 8'h00);
  endtask

  // strapped modes without a parallel bus must see no transfer at all
  task automatic refused(input hpp_mode_t m);
    logic any;
    any = 0;
    @(posedge sys_clk);
    mode <= m;
    req <= 1;
    repeat (20) begin
      @(posedge sys_clk);
      #1;
      any |= done | wr_pulse | rd_pulse | port.bus_dev_oe;
    end
    @(posedge sys_clk);
    req <= 0;
    #1;
    chk(any, 0);
    chk(port.host_bus_byte, 8'h00);
    chk(port.bus_host_oe, 1);
    chk(port.data_strobe_n, m != HPP_MODE_HW);
    chk(port.rd_n, m != HPP_MODE_HW);
  endtask

  // status change, level held while pending, then cleared and released
  task automatic irq_case(input int c, input logic en);
    @(posedge sys_clk);
    irq_enable <= en ? 2'b01 << c : 2'b00;
    status_in <= status_in ^ (2'b01 << c);
    repeat (10) @(posedge sys_clk);
    #1;
    chk(port.irq_n, !en);
    chk(irq_level, en);
    chk(pending[c], 1);
    @(posedge sys_clk);
    irq_clear <= 2'b11;
    @(posedge sys_clk);
    irq_clear <= 2'b00;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(port.irq_n, 1);
    chk(irq_level, 0);
  endtask

  // 200 MHz system clock
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // watchdog: whole run is well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end

  // main sequence: both bus styles, plain and multiplexed, then refusals and interrupts
  initial begin
    num_errors = 0;
    samples_checked = 0;
    sys_rst = 1;
    mode = HPP_MODE_STROBE;
    {muxed, req, req_write, req_addr, req_wdata, rd_data} = '0;
    {status_in, irq_enable, irq_clear} = '0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 0;
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk);
      mode <= m[0] ? HPP_MODE_RDWR : HPP_MODE_STROBE;
      muxed <= m[1];
      access(1, 8'(8'h5A + m), 8'(8'hA5 ^ m));
      access(0, 8'hFF, 8'(8'h3C + m));
      access(1, 8'h00, 8'hFF);
    end
    refused(HPP_MODE_HW);
    refused(HPP_MODE_SERIAL);
    irq_case(0, 1);
    irq_case(1, 1);
    irq_case(0, 0);
    stop_test();
  end
endmodule
`default_nettype wire

// ### verif/hpp_props.sv
`timescale 1ns/100ps
`default_nettype none
// passive watch on the shared pins between the two ends
module hpp_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] host_bus_byte,
  input wire logic bus_dev_oe,
  input wire logic bus_host_oe,
  input wire logic data_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic irq_dev_oe,
  input wire logic irq_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // both strobes grounded while the host holds the pins: hardware mode ties, no transfer
  logic hw_tie;
  assign hw_tie = !data_strobe_n && !rd_n && bus_host_oe;

  // strobe opening edge; it must close again before the next transfer
  sequence ds_open;
    data_strobe_n ##1 (!data_strobe_n && !hw_tie);
  endsequence

  a_irq_open_drain: assert property (irq_dev_oe |-> !irq_n)
    else $error("interrupt line not pulled low");
  a_rst_quiet: assert property ($past(sys_rst) |-> !irq_dev_oe && !bus_dev_oe)
    else $error("device drives pins out of reset");
  // turn-round only after the read strobe has stood two cycles
  a_drive_cause: assert property ($rose(bus_dev_oe) |-> !rd_n && $past(rd_n, 2) == 1'b0)
    else $error("device drives without read strobe");
  a_read_answer: assert property ($fell(rd_n) && !hw_tie |-> ##[1:10] bus_dev_oe)
    else $error("no read data driven");
  a_read_release: assert property ($rose(rd_n) |-> ##[0:5] !bus_dev_oe)
    else $error("device holds pins after read");
  a_no_fight: assert property (!(bus_dev_oe && bus_host_oe))
    else $error("both ends drive the pins");
  a_write_drive: assert property (!wr_n |-> bus_host_oe && !bus_dev_oe)
    else $error("write data not driven by host");
  a_addr_phase: assert property (ale |-> bus_host_oe && !bus_dev_oe)
    else $error("address phase not driven by host");
  a_addr_stable: assert property (ale && $past(ale) |-> $stable(host_bus_byte))
    else $error("address byte moves during address phase");
  a_strobe_close: assert property (ds_open |-> ##[2:10] data_strobe_n)
    else $error("strobe never closes");
endmodule
`default_nettype wire
